// ### sync_pulse_output.v
// sync pulse output with trigger duty and multi-unit alignment
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sync_pulse_defines.vh"

// Notes on behaviour
// - the shared connector turns to trigger duty during sweep or burst, else it is sync out.
// - with sync on, the connector drives a logic pulse train at the source frequency.
// - the source is channel one or two carrier, or channel one or two modulation.
// - sync goes quiet whenever the selected source frequency is above 10 MHz.
// - basic or arbitrary waves give one 25.6 ns pulse per period up to 10 MHz; here the pulse is one 40 ns core cycle.
// - noise or a dc level gives no pulses.
// - a bit sequence gives pulses at its bit rate.
// - internal analog modulation gives 25.6 ns pulses at the modulating rate; here each pulse is one 40 ns core cycle.
// - internal keying modulation gives pulses at the keying rate.
// - external modulation silences the sync output.
// - sweep or burst silences sync and hides its settings.
// - a master sends an alignment pulse on sync-device; a follower takes it from its pin.
// - each follower waits its own programmed delay before it aligns.
module sync_pulse_output (
   // clock and reset
   input  wire        core_clk,
   input  wire        rstn,
   // register port
   input  wire [3:0]  regAddr,
   input  wire [31:0] regWrData,
   input  wire        regWrite,
   input  wire        regRead,
   output reg  [31:0] regRdData,
   // channel state from the generator core
   input  wire        sweepOrBurst,
   input  wire [31:0] ch1PeriodCycles,
   input  wire [31:0] ch2PeriodCycles,
   input  wire [31:0] ch1ModPeriodCycles,
   input  wire [31:0] ch2ModPeriodCycles,
   input  wire [1:0]  ch1Kind,
   input  wire [1:0]  ch2Kind,
   input  wire [1:0]  ch1ModKind,
   input  wire [1:0]  ch2ModKind,
   // shared connector, three signals
   input  wire        trigSyncIn,
   output reg         trigSyncOut,
   output reg         trigSyncOe,
   // trigger duty, alignment and sync menu visibility towards the core
   output reg         trigDuty,
   output reg         trigInPulse,
   output reg         alignPulse,
   output reg         syncMenuVisible
);
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam [3:0] ADDR_CTRL   = 4'h0;
   localparam [3:0] ADDR_DELAY  = 4'h1;
   localparam [3:0] ADDR_STATUS = 4'h2;
   localparam [3:0] ADDR_CMD    = 4'h3;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   reg rstMeta;
   reg rstSync;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   reg        syncEnable_reg;
   reg [1:0]  syncSource_reg;
   reg        multiOn_reg;
   reg        isMaster_reg;
   reg [31:0] followerDelay_reg;
   reg        syncCmd_reg;

   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         syncEnable_reg    <= 1'b0;
         syncSource_reg    <= `SRC_CH1_CARRIER;
         multiOn_reg       <= 1'b0;
         isMaster_reg      <= 1'b0;
         followerDelay_reg <= 32'h0;
         syncCmd_reg       <= 1'b0;
      end else begin
         syncCmd_reg <= 1'b0;
         if (regWrite) begin
            case (regAddr)
               ADDR_CTRL: begin
                  syncEnable_reg <= regWrData[0];
                  syncSource_reg <= regWrData[2:1];
                  multiOn_reg    <= regWrData[3];
                  isMaster_reg   <= regWrData[4];
               end
               ADDR_DELAY: begin
                  followerDelay_reg <= regWrData;
               end
               ADDR_CMD: begin
                  syncCmd_reg <= regWrData[0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // source decode
   // ------------------------------------------------------------
   function srcAllowed;
      input [1:0] kind;
      input [1:0] modKind;
      input       isMod;
      begin
         if (isMod) begin
            // analog and keying both pulse at their own rate
            srcAllowed = (modKind == `MOD_ANALOG) || (modKind == `MOD_KEYING);
         end else begin
            // external modulation takes the aux connector, so silence
            srcAllowed = (kind != `KIND_NOISE_DC) && (modKind != `MOD_EXTERNAL);
         end
      end
   endfunction

   reg [31:0] srcPeriod;
   reg        srcOk;
   always @* begin
      case (syncSource_reg)
         `SRC_CH1_CARRIER: begin
            // bit sequence period is one bit time here
            srcPeriod = ch1PeriodCycles;
            srcOk     = srcAllowed(ch1Kind, ch1ModKind, 1'b0);
         end
         `SRC_CH2_CARRIER: begin
            srcPeriod = ch2PeriodCycles;
            srcOk     = srcAllowed(ch2Kind, ch2ModKind, 1'b0);
         end
         `SRC_CH1_MOD: begin
            srcPeriod = ch1ModPeriodCycles;
            srcOk     = srcAllowed(ch1Kind, ch1ModKind, 1'b1);
         end
         `SRC_CH2_MOD: begin
            srcPeriod = ch2ModPeriodCycles;
            srcOk     = srcAllowed(ch2Kind, ch2ModKind, 1'b1);
         end
         default: begin
            srcPeriod = 32'h0;
            srcOk     = 1'b0;
         end
      endcase
   end

   // a period shorter than the limit means a frequency above 10 MHz
   wire tooFast = (srcPeriod < `MIN_PERIOD_CYCLES);
   wire runSync = syncEnable_reg && srcOk && !tooFast && !sweepOrBurst;

   // ------------------------------------------------------------
   // pulse generation
   // ------------------------------------------------------------
   wire periodStart;
   period_timer u_period_timer (
      .clk          (core_clk),
      .rstn         (rstSync),
      .run          (runSync),
      .periodCycles (srcPeriod),
      .strike       (periodStart)
   );

   reg [31:0] widthCount_reg;
   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         widthCount_reg <= 32'h0;
      end else if (!runSync) begin
         widthCount_reg <= 32'h0;
      end else if (periodStart) begin
         widthCount_reg <= `PULSE_CYCLES;
      end else if (widthCount_reg != 32'h0) begin
         widthCount_reg <= widthCount_reg - 32'h1;
      end
   end
   wire syncLevel = runSync && (periodStart || (widthCount_reg > 32'h1));

   // ------------------------------------------------------------
   // multi-unit alignment
   // ------------------------------------------------------------
   // pin taken as synchronous; a rising edge is the alignment mark
   reg trigPrev_reg;
   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         trigPrev_reg <= 1'b0;
      end else begin
         trigPrev_reg <= trigSyncIn;
      end
   end
   wire trigEdge = trigSyncIn && !trigPrev_reg;
   wire listening = multiOn_reg && !isMaster_reg;

   wire followerFire;
   delay_line u_delay_line (
      .clk         (core_clk),
      .rstn        (rstSync),
      .start       (listening && trigEdge),
      .delayCycles (followerDelay_reg),
      .fire        (followerFire)
   );

   wire masterSend = multiOn_reg && isMaster_reg && syncCmd_reg;

   // ------------------------------------------------------------
   // connector and outputs
   // ------------------------------------------------------------
   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         trigSyncOut     <= 1'b0;
         trigSyncOe      <= 1'b0;
         trigDuty        <= `PORT_SYNC;
         trigInPulse     <= 1'b0;
         alignPulse      <= 1'b0;
         syncMenuVisible <= 1'b1;
      end else begin
         trigDuty        <= sweepOrBurst ? `PORT_TRIG : `PORT_SYNC;
         syncMenuVisible <= !sweepOrBurst;
         trigInPulse     <= sweepOrBurst && trigEdge;
         // master aligns itself on send, follower after its delay
         alignPulse      <= masterSend || followerFire;
         if (masterSend) begin
            trigSyncOut <= 1'b1;
            trigSyncOe  <= 1'b1;
         end else if (listening || sweepOrBurst) begin
            // trigger input duty or follower listening: release the pin
            trigSyncOut <= 1'b0;
            trigSyncOe  <= 1'b0;
         end else begin
            trigSyncOut <= syncLevel;
            trigSyncOe  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         regRdData <= 32'h0;
      end else if (regRead) begin
         case (regAddr)
            ADDR_CTRL:   regRdData <= {27'h0, isMaster_reg, multiOn_reg,
                                       syncSource_reg, syncEnable_reg};
            ADDR_DELAY:  regRdData <= followerDelay_reg;
            ADDR_STATUS: regRdData <= {28'h0, sweepOrBurst, tooFast, srcOk, runSync};
            default:     regRdData <= 32'h0;
         endcase
      end else begin
         regRdData <= 32'h0;
      end
   end
endmodule
`default_nettype wire

// ### sync_pulse_defines.vh
// timing counts, selector codes and source kinds for the sync pulse output
`ifndef SYNC_PULSE_DEFINES_VH
`define SYNC_PULSE_DEFINES_VH

// core clock in kHz, and the documented figures in their own units
`define CORE_CLK_KHZ       32'd25000
`define PULSE_WIDTH_PS     32'd25600
`define SYNC_LIMIT_KHZ     32'd10000

// pulse width in cycles, rounded up: ceil(25600 ps * 25 MHz) = 1
`define PULSE_CYCLES       (((`PULSE_WIDTH_PS * 32'd25) + 32'd999999) / 32'd1000000)
// shortest legal source period in cycles, rounded up
`define MIN_PERIOD_CYCLES  ((`CORE_CLK_KHZ + `SYNC_LIMIT_KHZ - 32'd1) / `SYNC_LIMIT_KHZ)

// sync source selector
`define SRC_CH1_CARRIER    2'h0
`define SRC_CH2_CARRIER    2'h1
`define SRC_CH1_MOD        2'h2
`define SRC_CH2_MOD        2'h3

// carrier waveform kind
`define KIND_BASIC         2'h0
`define KIND_ARB           2'h1
`define KIND_NOISE_DC      2'h2
`define KIND_PSEUDO_RANDOM_BIT_SEQUENCE          2'h3

// modulation kind
`define MOD_NONE           2'h0
`define MOD_ANALOG         2'h1
`define MOD_KEYING         2'h2
`define MOD_EXTERNAL       2'h3

// connector duty
`define PORT_SYNC          1'b0
`define PORT_TRIG          1'b1

`endif

// ### period_timer.v
// period counter: one start strike per programmed source period
`timescale 1ns/1ps
`default_nettype none
`include "sync_pulse_defines.vh"

module period_timer (
   // clock and reset
   input  wire        clk,
   input  wire        rstn,
   // control
   input  wire        run,
   input  wire [31:0] periodCycles,
   // result
   output reg         strike
);
   reg [31:0] count_reg;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= 32'h0;
         strike    <= 1'b0;
      end else if (!run) begin
         // restart aligned so the first pulse opens a period
         count_reg <= 32'h0;
         strike    <= 1'b0;
      end else if (count_reg == 32'h0) begin
         count_reg <= periodCycles - 32'h1;
         strike    <= 1'b1;
      end else begin
         count_reg <= count_reg - 32'h1;
         strike    <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### delay_line.v
// follower delay: fires once, one cycle more than the programmed count after an alignment pulse
`timescale 1ns/1ps
`default_nettype none

module delay_line (
   // clock and reset
   input  wire        clk,
   input  wire        rstn,
   // control
   input  wire        start,
   input  wire [31:0] delayCycles,
   // result
   output reg         fire
);
   reg [31:0] count_reg;
   reg        busy_reg;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= 32'h0;
         busy_reg  <= 1'b0;
         fire      <= 1'b0;
      end else if (start) begin
         // a fresh alignment restarts the wait
         count_reg <= delayCycles;
         busy_reg  <= 1'b1;
         fire      <= 1'b0;
      end else if (busy_reg && count_reg == 32'h0) begin
         busy_reg  <= 1'b0;
         fire      <= 1'b1;
      end else begin
         if (busy_reg) begin
            count_reg <= count_reg - 32'h1;
         end
         fire <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### sync_pulse_output_properties.sv
// checker: port-level properties of the sync pulse output
`timescale 1ns/1ps
`default_nettype none
`include "sync_pulse_defines.vh"
module sync_pulse_output_checker (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // core side
   input wire logic       sweepOrBurst,
   input wire logic [1:0] ch1Kind,
   input wire logic [1:0] ch2Kind,
   input wire logic [1:0] ch1ModKind,
   input wire logic [1:0] ch2ModKind,
   // connector and results
   input wire logic       trigSyncIn,
   input wire logic       trigSyncOut,
   input wire logic       trigSyncOe,
   input wire logic       trigDuty,
   input wire logic       trigInPulse,
   input wire logic       alignPulse,
   input wire logic       syncMenuVisible
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // every source silent: both carriers noise, both modulations external
   wire quiet = ch1Kind == `KIND_NOISE_DC && ch2Kind == `KIND_NOISE_DC
      && ch1ModKind == `MOD_EXTERNAL && ch2ModKind == `MOD_EXTERNAL;
   // ------------------------------
   // properties
   // ------------------------------
   AST_DUTY_ON: assert property ($rose(sweepOrBurst) |-> ##[1:2] trigDuty)
      else $error("trigger duty not taken");
   AST_DUTY_OFF: assert property ($fell(sweepOrBurst) |-> ##[1:2] !trigDuty)
      else $error("trigger duty not left");
   AST_HIDDEN: assert property (sweepOrBurst [*3] |-> !syncMenuVisible)
      else $error("sync menu shown in sweep");
   AST_PULSE: assert property (trigSyncOut && !alignPulse |=> !trigSyncOut [*2])
      else $error("sync pulse too wide or too close");
   AST_SILENT: assert property (quiet [*3] |-> !trigSyncOut || alignPulse)
      else $error("pulse from a silent source");
   AST_DRIVE: assert property (trigSyncOut |-> trigSyncOe)
      else $error("pin high but not driven");
   AST_TRIGIN: assert property (trigDuty && $rose(trigSyncIn) |-> ##[1:3] trigInPulse)
      else $error("trigger input edge lost");
   AST_ALIGN: assert property (alignPulse && trigSyncOe |-> trigSyncOut)
      else $error("master alignment not on pin");
   COV_PULSE: cover property (trigSyncOut ##3 trigSyncOut);
   COV_ALIGN: cover property (alignPulse);
   COV_TRIG: cover property (trigInPulse);
endmodule
`default_nettype wire

// ### far_end_model.sv
// far instrument on the shared connector: drives pulses, times edges
`timescale 1ns/1ps
`default_nettype none
module far_end_model (
   // clock
   input wire logic clk,
   // connector
   input wire logic outLevel,
   input wire logic outEnable,
   input wire logic sendPulse,
   output logic     pinLevel,
   // observations
   output var int   edgeCount,
   output var int   lastGap
);
   int   cnt = 0;
   logic prev = 1'b0;
   // far side drives only while the block has released the pin
   assign pinLevel = outEnable ? outLevel : sendPulse;
   initial edgeCount = 0;
   initial lastGap = 0;
   always @(posedge clk) begin
      prev <= pinLevel;
      cnt <= cnt + 1;
      if (pinLevel && !prev && outEnable) begin
         edgeCount <= edgeCount + 1;
         lastGap <= cnt;
         cnt <= 1;
      end
   end
endmodule
`default_nettype wire

// ### tb_sync_pulse_output.sv
// testbench of the sync pulse output
`timescale 1ns/1ps
`default_nettype none
`include "sync_pulse_defines.vh"
module tb_sync_pulse_output;
   logic        core_clk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic [3:0]  regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0, p1 = 32'h4, p2 = 32'h4, m1 = 32'h4, m2 = 32'h4;
   logic [1:0]  k1 = 2'h0, k2 = 2'h0, mk1 = 2'h0, mk2 = 2'h0;
   logic        sweepOrBurst = 1'b0, sendPulse = 1'b0, sawTrig = 1'b0, rdWas = 1'b0;
   wire  [31:0] regRdData;
   wire         pin, trigSyncOut, trigSyncOe, trigDuty, trigInPulse, alignPulse, syncMenuVisible;
   int          edgeCount, lastGap, n, c0, bad_count = 0, n_checks = 0;
   logic [31:0] seed = 32'h57, per [4];
   logic [63:0] q [$];
   always #20 core_clk = ~core_clk;
   sync_pulse_output u_sync_pulse_output (.core_clk, .rstn, .regAddr, .regWrData, .regWrite,
      .regRead, .regRdData, .sweepOrBurst, .ch1PeriodCycles(p1), .ch2PeriodCycles(p2),
      .ch1ModPeriodCycles(m1), .ch2ModPeriodCycles(m2), .ch1Kind(k1), .ch2Kind(k2),
      .ch1ModKind(mk1), .ch2ModKind(mk2), .trigSyncIn(pin), .trigSyncOut, .trigSyncOe,
      .trigDuty, .trigInPulse, .alignPulse, .syncMenuVisible);
   far_end_model u_far_end_model (.clk(core_clk), .outLevel(trigSyncOut), .outEnable(trigSyncOe),
      .sendPulse, .pinLevel(pin), .edgeCount, .lastGap);
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ------------------------------
   // register bus, one idle cycle after each strobe
   // ------------------------------
   task wr(input logic [3:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge core_clk) regWrite <= 1'b0;
      @(posedge core_clk);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] e);
      q.push_back({mask, e});
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk) regRead <= 1'b0;
      @(posedge core_clk);
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rdWas) chk("read", q[0][63:32] & q[0][31:0], q[0][63:32] & regRdData);
      if (rdWas) void'(q.pop_front());
      rdWas <= regRead;
      if (trigInPulse === 1'b1) sawTrig <= 1'b1;
   end
   task quietFor(input string nm); // silent span: far end counts no edges
      c0 = edgeCount;
      repeat (30) @(posedge core_clk);
      chk(nm, 32'(c0), 32'(edgeCount));
   endtask
   task waitAlign(); // cycles from request until the alignment pulse, at most 40
      n = 0;
      repeat (40) begin
         @(posedge core_clk) regWrite <= 1'b0;
         sendPulse <= 1'b0;
         n++;
         #1 if (alignPulse === 1'b1) break;
      end
   endtask
   initial begin
      #400000 bad_count++;
      results();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      chk("menu at reset", 32'h1, 32'(syncMenuVisible));
      chk("out at reset", 32'h0, 32'({trigSyncOut, trigDuty}));
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(4'h9, 32'hffffffff, 32'h0); // unmapped index reads zero
      per[0] = 32'h3;
      for (int i = 1; i < 4; i++) per[i] = 32'h3 + (rnd() & 32'h7);
      {p1, p2, m1, m2} <= {per[0], per[1], per[2], per[3]};
      {k1, k2, mk1, mk2} <= {`KIND_ARB, `KIND_PSEUDO_RANDOM_BIT_SEQUENCE, `MOD_ANALOG, `MOD_KEYING};
      for (int s = 0; s < 4; s++) begin
         wr(4'h0, 32'((s << 1) | 1));
         repeat (30) @(posedge core_clk);
         chk("pulse gap", per[s], 32'(lastGap));
      end
      p1 <= 32'h2;
      wr(4'h0, 32'h1);
      quietFor("too fast");
      rd(4'h2, 32'h4, 32'h4);
      {k1, k2, mk1, mk2} <= {`KIND_NOISE_DC, `KIND_NOISE_DC, `MOD_EXTERNAL, `MOD_EXTERNAL};
      p1 <= 32'h4;
      quietFor("noise");
      wr(4'h0, 32'h5);
      quietFor("external");
      {k1, mk1} <= {`KIND_BASIC, `MOD_ANALOG};
      sweepOrBurst <= 1'b1;
      quietFor("sweep");
      chk("duty menu", 32'h2, 32'({trigDuty, syncMenuVisible}));
      rd(4'h2, 32'h8, 32'h8);
      sendPulse <= 1'b1;
      @(posedge core_clk) sendPulse <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("trigger in", 32'h1, 32'(sawTrig));
      sweepOrBurst <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("duty back", 32'h0, 32'(trigDuty));
      wr(4'h0, 32'h18);
      {regAddr, regWrData, regWrite} <= {4'h3, 32'h1, 1'b1};
      waitAlign();
      chk("master delay", 32'h2, 32'(n));
      chk("master pin", 32'h1, 32'(trigSyncOut & trigSyncOe));
      per[0] = 32'h2 + (rnd() & 32'h7);
      wr(4'h1, per[0]);
      wr(4'h0, 32'h8);
      sendPulse <= 1'b1;
      waitAlign();
      chk("follower delay", per[0] + 32'h3, 32'(n));
      chk("follower oe", 32'h0, 32'(trigSyncOe));
      repeat (3) @(posedge core_clk);
      results();
   end
endmodule
bind sync_pulse_output sync_pulse_output_checker u_sync_pulse_output_checker (.core_clk, .rstn,
   .sweepOrBurst, .ch1Kind, .ch2Kind, .ch1ModKind, .ch2ModKind, .trigSyncIn, .trigSyncOut,
   .trigSyncOe, .trigDuty, .trigInPulse, .alignPulse, .syncMenuVisible);
`default_nettype wire
